// >>> core/lmft_pkg.sv
/*
 * constants for the movie, flash timer and inhibit control registers:
 * register offsets, field positions, reset values, timer figures.
 * assumes a single 8-bit register space reached over the two-wire control port.
 */
package lmft_pkg;
    // ==========================================================
    // register offsets
    localparam logic [7:0] LMFT_ADDR_STATUS = 8'h18;
    localparam logic [7:0] LMFT_ADDR_MOVIE = 8'h1A;
    localparam logic [7:0] LMFT_ADDR_TIMER = 8'h1B;
    localparam logic [7:0] LMFT_ADDR_INHIBIT = 8'h1C;

    // ==========================================================
    // field positions and writable masks
    localparam int LMFT_MOVIE_LVL_LSB = 4;
    localparam int LMFT_MOVIE_EN1_BIT = 1;
    localparam int LMFT_MOVIE_EN2_BIT = 0;
    localparam int LMFT_TIMER_CODE_LSB = 1;
    localparam int LMFT_TIMEOUT_MODE_BIT = 0;
    localparam int LMFT_ST_EV1_BIT = 5;
    localparam int LMFT_ST_EV2_BIT = 4;
    localparam int LMFT_ST_TRIG_BIT = 3;
    localparam int LMFT_ST_INH_BIT = 2;
    localparam int LMFT_ST_RUN_BIT = 0;
    localparam logic [7:0] LMFT_MOVIE_MASK = 8'h73;
    localparam logic [7:0] LMFT_TIMER_MASK = 8'h3F;
    localparam logic [7:0] LMFT_INHIBIT_MASK = 8'h0F;

    // ==========================================================
    // reset values
    localparam logic [7:0] LMFT_MOVIE_RESET = 8'h00;
    localparam logic [7:0] LMFT_TIMER_RESET = 8'h24;
    localparam logic [7:0] LMFT_INHIBIT_RESET = 8'h00;

    // ==========================================================
    // flash timer, in internal master clock periods
    localparam int LMFT_TIMER_BASE_PERIODS = 300000;
    localparam int LMFT_TIMER_MAX_PERIODS = 3000000;
    localparam logic [4:0] LMFT_TIMER_MAX_CODE = 5'h12;
    localparam int LMFT_TIMER_STEP_PERIODS =
        (LMFT_TIMER_MAX_PERIODS - LMFT_TIMER_BASE_PERIODS) / 18;
    localparam int LMFT_TIMER_WIDTH = 22;

    // ==========================================================
    // control port
    localparam logic [6:0] LMFT_DEV_ADDR = 7'h40; // arbitrary value

    typedef enum logic [2:0] {
        LMFT_IDLE = 3'b000,
        LMFT_ADDR = 3'b001,
        LMFT_ADDR_ACK = 3'b010,
        LMFT_PTR = 3'b011,
        LMFT_PTR_ACK = 3'b100,
        LMFT_WDATA = 3'b101,
        LMFT_RDATA = 3'b110,
        LMFT_RACK = 3'b111
    } lmft_state_t;
endpackage

// >>> core/lmft_regs.sv
/*
 * movie current, flash timer and flash inhibit control registers with the
 * flash on-time timer, behind a two-wire control port slave.
 * assumes clk is the external master clock and the bus master keeps
 * scl slow against clk (at least 8 clk periods per scl half period).
 */
// What this block does
// - movie level field 6:4 selects movie drive
// - bit 1 enables first led, resets off
// - bit 0 enables second led, resets off
// - timer code sets on-time, clamps at 10010
// - mode clear: only timer expiry ends flash
// - mode set: trigger low or expiry ends
// - inhibit level field 3:0, 50 mA steps
// - timer ticks on clock, optionally halved
// - status flag high while timer runs
// - movie event flags when movie current delivered
`timescale 1ns/1ps
module lmft_regs
    import lmft_pkg::*;
#(
    parameter int TIMER_BASE_PERIODS = LMFT_TIMER_BASE_PERIODS,
    parameter int TIMER_STEP_PERIODS = LMFT_TIMER_STEP_PERIODS
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic flash_trigger_pin,
    input wire logic flash_inhibit_pin,
    input wire logic master_clock_halve,
    output logic [2:0] movie_drive_level,
    output logic movie_enable_first,
    output logic movie_enable_second,
    output logic [3:0] inhibit_drive_level,
    output logic flash_timer_running,
    output logic flash_inhibited,
    output logic movie_event_first,
    output logic movie_event_second
);
    // ==========================================================
    // input synchronisers; stage 3 only feeds edge detection
    logic [2:0] scl_sync, sda_sync;
    logic [1:0] trig_sync, inh_sync, halve_sync;
    logic trig_d;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_sync <= 3'h7;
            sda_sync <= 3'h7;
            trig_sync <= 2'h0;
            inh_sync <= 2'h0;
            halve_sync <= 2'h0;
            trig_d <= 1'b0;
        end else begin
            scl_sync <= {scl_sync[1:0], scl_in};
            sda_sync <= {sda_sync[1:0], sda_in};
            trig_sync <= {trig_sync[0], flash_trigger_pin};
            inh_sync <= {inh_sync[0], flash_inhibit_pin};
            halve_sync <= {halve_sync[0], master_clock_halve};
            trig_d <= trig_sync[1];
        end
    end

    logic scl_s, sda_s, scl_rise, scl_fall, bus_start, bus_stop;
    assign scl_s = scl_sync[1];
    assign sda_s = sda_sync[1];
    assign scl_rise = scl_s & ~scl_sync[2];
    assign scl_fall = ~scl_s & scl_sync[2];
    assign bus_start = scl_s & scl_sync[2] & ~sda_s & sda_sync[2];
    assign bus_stop = scl_s & scl_sync[2] & sda_s & ~sda_sync[2];

    // ==========================================================
    // control port slave and register file
    lmft_state_t state, next_state;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [7:0] shift, next_shift;
    logic [7:0] pointer, next_pointer;
    logic [7:0] movie_reg, next_movie_reg;
    logic [7:0] timer_reg, next_timer_reg;
    logic [7:0] inhibit_reg, next_inhibit_reg;
    logic next_sda_oe;
    logic [7:0] read_data;

    // reserved bits are masked at write so they always read zero
    always_comb begin
        case (pointer)
            LMFT_ADDR_MOVIE: read_data = movie_reg;
            LMFT_ADDR_TIMER: read_data = timer_reg;
            LMFT_ADDR_INHIBIT: read_data = inhibit_reg;
            LMFT_ADDR_STATUS: begin
                read_data = 8'h00;
                read_data[LMFT_ST_EV1_BIT] = movie_event_first;
                read_data[LMFT_ST_EV2_BIT] = movie_event_second;
                read_data[LMFT_ST_TRIG_BIT] = trig_sync[1];
                read_data[LMFT_ST_INH_BIT] = inh_sync[1];
                read_data[LMFT_ST_RUN_BIT] = flash_timer_running;
            end
            default: read_data = 8'h00;
        endcase
    end

    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shift = shift;
        next_pointer = pointer;
        next_movie_reg = movie_reg;
        next_timer_reg = timer_reg;
        next_inhibit_reg = inhibit_reg;
        next_sda_oe = sda_oe;
        if (bus_stop) begin
            next_state = LMFT_IDLE;
            next_sda_oe = 1'b0;
        end else if (bus_start) begin
            next_state = LMFT_ADDR;
            next_bit_cnt = 4'h0;
            next_sda_oe = 1'b0;
        end else begin
            case (state)
                LMFT_ADDR, LMFT_PTR, LMFT_WDATA: begin
                    if (scl_rise) begin
                        next_shift = {shift[6:0], sda_s};
                        next_bit_cnt = bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == 4'h8) begin
                        next_sda_oe = 1'b1;
                        next_bit_cnt = 4'h0;
                        next_state = LMFT_PTR_ACK;
                        if (state == LMFT_ADDR) begin
                            next_state = LMFT_ADDR_ACK;
                            if (shift[7:1] != LMFT_DEV_ADDR) begin
                                next_sda_oe = 1'b0;
                                next_state = LMFT_IDLE;
                            end
                        end else if (state == LMFT_PTR) begin
                            next_pointer = shift;
                        end else begin
                            case (pointer)
                                LMFT_ADDR_MOVIE: next_movie_reg = shift & LMFT_MOVIE_MASK;
                                LMFT_ADDR_TIMER: next_timer_reg = shift & LMFT_TIMER_MASK;
                                LMFT_ADDR_INHIBIT: next_inhibit_reg = shift & LMFT_INHIBIT_MASK;
                                default: ;
                            endcase
                            next_pointer = pointer + 8'h01;
                        end
                    end
                end
                LMFT_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (shift[0]) begin
                            next_shift = read_data;
                            next_sda_oe = ~read_data[7];
                            next_state = LMFT_RDATA;
                        end else begin
                            next_sda_oe = 1'b0;
                            next_state = LMFT_PTR;
                        end
                    end
                end
                LMFT_PTR_ACK: begin
                    if (scl_fall) begin
                        next_sda_oe = 1'b0;
                        next_state = LMFT_WDATA;
                    end
                end
                LMFT_RDATA: begin
                    if (scl_fall) begin
                        next_bit_cnt = bit_cnt + 4'h1;
                        next_shift = {shift[6:0], 1'b0};
                        next_sda_oe = ~shift[6];
                        if (bit_cnt == 4'h7) begin
                            next_sda_oe = 1'b0;
                            next_bit_cnt = 4'h0;
                            next_pointer = pointer + 8'h01;
                            next_state = LMFT_RACK;
                        end
                    end
                end
                LMFT_RACK: begin
                    if (scl_rise && sda_s) begin
                        next_state = LMFT_IDLE;
                    end else if (scl_fall) begin
                        next_shift = read_data;
                        next_sda_oe = ~read_data[7];
                        next_state = LMFT_RDATA;
                    end
                end
                default: next_sda_oe = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= LMFT_IDLE;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            pointer <= 8'h00;
            movie_reg <= LMFT_MOVIE_RESET;
            timer_reg <= LMFT_TIMER_RESET;
            inhibit_reg <= LMFT_INHIBIT_RESET;
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            shift <= next_shift;
            pointer <= next_pointer;
            movie_reg <= next_movie_reg;
            timer_reg <= next_timer_reg;
            inhibit_reg <= next_inhibit_reg;
            sda_oe <= next_sda_oe;
            sda_out <= 1'b0;
        end
    end

    // ==========================================================
    // flash timer and driver controls
    logic [4:0] timer_code;
    logic [LMFT_TIMER_WIDTH-1:0] limit, count, next_count;
    logic tick_phase, next_tick_phase, tick, next_running, expire;
    logic [2:0] next_movie_level;
    logic next_en1, next_en2, next_ev1, next_ev2, next_inhibited;
    logic [3:0] next_inh_level;

    always_comb begin
        timer_code = timer_reg[LMFT_TIMER_CODE_LSB +: 5];
        if (timer_code > LMFT_TIMER_MAX_CODE) begin
            timer_code = LMFT_TIMER_MAX_CODE;
        end
        limit = LMFT_TIMER_WIDTH'(TIMER_BASE_PERIODS
                + int'(timer_code) * TIMER_STEP_PERIODS);
        next_tick_phase = halve_sync[1] ? ~tick_phase : 1'b0;
        tick = ~halve_sync[1] | tick_phase;
        expire = flash_timer_running && tick && (count == limit - 1'b1);
        next_count = count;
        next_running = flash_timer_running;
        if (!flash_timer_running) begin
            next_count = '0;
            next_running = trig_sync[1] & ~trig_d;
        end else if (expire) begin
            next_running = 1'b0;
        end else if (timer_reg[LMFT_TIMEOUT_MODE_BIT] && !trig_sync[1]) begin
            next_running = 1'b0;
        end else if (tick) begin
            next_count = count + 1'b1;
        end
        next_movie_level = movie_reg[LMFT_MOVIE_LVL_LSB +: 3];
        next_en1 = movie_reg[LMFT_MOVIE_EN1_BIT];
        next_en2 = movie_reg[LMFT_MOVIE_EN2_BIT];
        next_ev1 = next_en1 && next_movie_level != 3'h0;
        next_ev2 = next_en2 && next_movie_level != 3'h0;
        // reserved codes pass through unchanged; the host must avoid them
        next_inh_level = inhibit_reg[3:0];
        next_inhibited = next_running & inh_sync[1];
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= '0;
            tick_phase <= 1'b0;
            flash_timer_running <= 1'b0;
            movie_drive_level <= 3'h0;
            movie_enable_first <= 1'b0;
            movie_enable_second <= 1'b0;
            movie_event_first <= 1'b0;
            movie_event_second <= 1'b0;
            inhibit_drive_level <= 4'h0;
            flash_inhibited <= 1'b0;
        end else begin
            count <= next_count;
            tick_phase <= next_tick_phase;
            flash_timer_running <= next_running;
            movie_drive_level <= next_movie_level;
            movie_enable_first <= next_en1;
            movie_enable_second <= next_en2;
            movie_event_first <= next_ev1;
            movie_event_second <= next_ev2;
            inhibit_drive_level <= next_inh_level;
            flash_inhibited <= next_inhibited;
        end
    end
endmodule

// >>> dv/lmft_regs_sva.sv
/* port checker for lmft_regs: level outputs, event flags, flash timer length.
   assumes the bench holds trigger and halve steady around each flash. */
`timescale 1ns/1ps
module lmft_regs_sva
    import lmft_pkg::*;
#(
    parameter int TIMER_BASE_PERIODS = 10,
    parameter int TIMER_STEP_PERIODS = 5
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic flash_trigger_pin,
    input wire logic flash_inhibit_pin,
    input wire logic master_clock_halve,
    input wire logic [2:0] movie_drive_level,
    input wire logic movie_enable_first,
    input wire logic movie_enable_second,
    input wire logic [3:0] inhibit_drive_level,
    input wire logic flash_timer_running,
    input wire logic flash_inhibited,
    input wire logic movie_event_first,
    input wire logic movie_event_second
);
    // halved clock doubles the longest flash; a few clk of slack for the edges
    localparam int MAX_LEN = 2 * (TIMER_BASE_PERIODS + 18 * TIMER_STEP_PERIODS) + 4;
    // ==========================================================
    // run length counter
    logic [31:0] run_len;
    logic [31:0] next_run_len;
    always_comb begin
        next_run_len = flash_timer_running ? run_len + 32'h1 : 32'h0;
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            run_len <= 32'h0;
        end else begin
            run_len <= next_run_len;
        end
    end
    // ==========================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    AST_EV_FIRST: assert property (
        (movie_enable_first && movie_drive_level != 3'h0) [*2] |-> movie_event_first)
        else $error("first movie event flag missing");
    AST_EV_FIRST_OFF: assert property (
        (!movie_enable_first) [*2] |-> !movie_event_first) else $error("first event while off");
    AST_EV_SECOND: assert property (
        (movie_enable_second && movie_drive_level != 3'h0) [*2] |-> movie_event_second)
        else $error("second movie event flag missing");
    AST_INHIBIT: assert property (
        flash_inhibited |-> flash_timer_running || $past(flash_timer_running))
        else $error("inhibit outside a flash");
    AST_START: assert property (
        $rose(flash_timer_running) |-> $past(flash_trigger_pin, 2))
        else $error("timer started without trigger");
    AST_MAX_LEN: assert property (
        run_len <= MAX_LEN) else $error("flash longer than the clamp");
    AST_MIN_LEN: assert property (
        $fell(flash_timer_running) && $past(flash_trigger_pin, 4) |->
        run_len >= (master_clock_halve ? 2 * TIMER_BASE_PERIODS - 2 : TIMER_BASE_PERIODS - 1))
        else $error("flash shorter than the base time");
    AST_NO_RESTART: assert property (
        $fell(flash_timer_running) |-> !flash_timer_running [*3]) else $error("flash restarted");
    AST_RESET_VAL: assert property (
        $rose(rst_b) |-> movie_drive_level == 3'h0 && !movie_enable_first
        && !movie_enable_second && inhibit_drive_level == 4'h0) else $error("bad reset level");
endmodule

// >>> dv/lmft_host.sv
/* host model: bit-banged two-wire master on the control port.
   assumes the bench resolves the data wire with a pull-up. */
`timescale 1ns/1ps
module lmft_host
    import lmft_pkg::*;
(
    input wire logic clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_lo,
    output logic rd_valid,
    output logic [7:0] rd_byte
);
    initial begin
        scl = 1'b1;
        sda_lo = 1'b0;
        rd_valid = 1'b0;
        rd_byte = 8'h00;
    end
    // ten clk per half period stays above the slave's eight-clk minimum
    task automatic half();
        repeat (10) @(negedge clk);
    endtask
    // data moves one clk after scl falls, never beside an scl edge
    task automatic bit_io(input logic b, output logic r);
        sda_lo = !b;
        half();
        scl = 1'b1;
        half();
        r = sda_line;
        scl = 1'b0;
        @(negedge clk);
    endtask
    task automatic start();
        sda_lo = 1'b0;
        half();
        scl = 1'b1;
        half();
        sda_lo = 1'b1;
        half();
        scl = 1'b0;
        @(negedge clk);
    endtask
    // data rises while scl is high; leaves scl high and the line released
    task automatic stop();
        sda_lo = 1'b1;
        half();
        scl = 1'b1;
        half();
        sda_lo = 1'b0;
        half();
    endtask
    task automatic send(input logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
    endtask
    task automatic write_reg(input logic [7:0] ptr, input logic [7:0] d);
        if (ptr == LMFT_ADDR_INHIBIT) d[3] = 1'b0;
        start();
        send({LMFT_DEV_ADDR, 1'b0});
        send(ptr);
        send(d);
        stop();
    endtask
    task automatic read_reg(input logic [6:0] dev, input logic [7:0] ptr);
        logic [7:0] v;
        logic r;
        start();
        send({LMFT_DEV_ADDR, 1'b0});
        send(ptr);
        start();
        send({dev, 1'b1});
        for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
        bit_io(1'b1, r);
        stop();
        rd_byte = v;
        rd_valid = 1'b1;
        @(negedge clk);
        rd_valid = 1'b0;
    endtask
endmodule

// >>> dv/lmft_regs_tb.sv
/* bench for lmft_regs: host model on the control port, flash pins from here.
   assumes lmft_host and lmft_regs_sva are compiled before this file. */
`timescale 1ns/1ps
module lmft_regs_tb;
    import lmft_pkg::*;
    localparam int BASE = 10;
    localparam int STEP = 5;
    logic clk, rst_b, scl, sda_lo, sda_oe, sda_out, trig, inh, halve, rd_valid;
    logic run, inhd, ev1, ev2, en1, en2;
    logic [2:0] lvl;
    logic [3:0] inh_lvl;
    logic [7:0] rd_byte;
    logic [7:0] exp_q[$];
    int n_fail = 0;
    int samples_checked = 0;
    wire sda_line = !(sda_lo || (sda_oe && !sda_out));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    lmft_regs #(.TIMER_BASE_PERIODS(BASE), .TIMER_STEP_PERIODS(STEP)) i_dut (.clk(clk),
        .rst_b(rst_b), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .flash_trigger_pin(trig), .flash_inhibit_pin(inh), .master_clock_halve(halve),
        .movie_drive_level(lvl), .movie_enable_first(en1), .movie_enable_second(en2),
        .inhibit_drive_level(inh_lvl), .flash_timer_running(run), .flash_inhibited(inhd),
        .movie_event_first(ev1), .movie_event_second(ev2));
    lmft_host i_host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_lo(sda_lo),
        .rd_valid(rd_valid), .rd_byte(rd_byte));
    // ==========================================================
    // checking
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    always @(posedge clk) begin
        if (rd_valid === 1'b1) check("read", exp_q.pop_front(), rd_byte);
    end
    task automatic rd(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        i_host.read_reg(dev, a);
    endtask
    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // counts running cycles; drop lowers the trigger after that many
    task automatic flash(input logic [4:0] code, input logic mode, input logic h,
                         input int drop, input int lo, input int hi);
        int n;
        n = 0;
        i_host.write_reg(LMFT_ADDR_TIMER, {2'b11, code, mode});
        rd(LMFT_DEV_ADDR, LMFT_ADDR_TIMER, {2'b00, code, mode});
        halve = h;
        inh = 1'($urandom);
        repeat (5) @(negedge clk);
        trig = 1'b1;
        for (int i = 0; i < 20 && run !== 1'b1; i++) @(negedge clk);
        while (run === 1'b1 && n < 250) begin
            n++;
            if (n == drop) trig = 1'b0;
            if (n == 5) check("inhibited", {7'h0, inh}, {7'h0, inhd});
            @(negedge clk);
        end
        check("run_len_ok", 8'h1, {7'h0, n >= lo && n <= hi});
        trig = 1'b0;
        repeat (8) @(negedge clk);
    endtask
    // ==========================================================
    // main sequence
    initial begin
        logic [1:0] e;
        rst_b = 1'b0;
        trig = 1'b0;
        inh = 1'b0;
        halve = 1'b0;
        void'($urandom(1));
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        rd(LMFT_DEV_ADDR, LMFT_ADDR_MOVIE, LMFT_MOVIE_RESET);
        rd(LMFT_DEV_ADDR, LMFT_ADDR_TIMER, LMFT_TIMER_RESET);
        rd(LMFT_DEV_ADDR, LMFT_ADDR_INHIBIT, LMFT_INHIBIT_RESET);
        i_host.write_reg(8'h1F, 8'hFF);
        rd(LMFT_DEV_ADDR, 8'h1F, 8'h00);
        // nobody answers a foreign address, so the pulled-up line reads all ones
        rd(7'h41, LMFT_ADDR_MOVIE, 8'hFF);
        for (int c = 0; c < 8; c++) begin
            e = 2'($urandom);
            i_host.write_reg(LMFT_ADDR_MOVIE, {1'b1, 3'(c), 2'b11, e});
            i_host.write_reg(LMFT_ADDR_INHIBIT, {5'h1F, 3'(c)});
            check("level", {5'h0, 3'(c)}, {5'h0, lvl});
            check("enables", {6'h0, e}, {6'h0, en1, en2});
            check("inh_level", {5'h0, 3'(c)}, {4'h0, inh_lvl});
            rd(LMFT_DEV_ADDR, LMFT_ADDR_MOVIE, {1'b0, 3'(c), 2'b00, e});
            rd(LMFT_DEV_ADDR, LMFT_ADDR_INHIBIT, {5'h0, 3'(c)});
            rd(LMFT_DEV_ADDR, LMFT_ADDR_STATUS, {2'b0, e & {2{c != 0}}, 4'h0});
        end
        flash(5'h00, 1'b0, 1'b0, 3, BASE, BASE + 1);
        flash(5'h05, 1'b0, 1'b1, 0, 2 * (BASE + 5 * STEP) - 1, 2 * (BASE + 5 * STEP) + 1);
        flash(5'h12, 1'b1, 1'b0, 8, 10, 14);
        flash(5'h12, 1'b1, 1'b0, 0, BASE + 18 * STEP, BASE + 18 * STEP + 1);
        flash(5'h1F, 1'b0, 1'b0, 0, BASE + 18 * STEP, BASE + 18 * STEP + 1);
        tally_and_finish();
    end
    // under twice the expected run, and inside the overall cycle budget
    initial begin
        #1600000;
        n_fail++;
        tally_and_finish();
    end
endmodule
bind lmft_regs lmft_regs_sva #(.TIMER_BASE_PERIODS(TIMER_BASE_PERIODS),
    .TIMER_STEP_PERIODS(TIMER_STEP_PERIODS)) i_sva (.*);
